/* File: rtl/mdm_device.sv */
// Device end: frame decoder, direct registers and indirect extended spaces
// Functional notes
// - Station keeps mdc at most 24 MHz, may stop
// - Data line sampled on each mdc rising edge
// - Capture 4-bit address straps, answer only matches
// - Bus idle one mdc cycle after reset
// - Register field selects one of 32 16-bit registers
// - Frame starts with 0 then 1 after idle
// - Start, op, device, register, turnaround, data order
// - Read: release, drive zero, then 16 data bits
// - Write: station drives 1,0 turnaround and data
// - Access control at 0xD, address/data at 0xE
// - Access control bits 4:0 pick target space
// - Targets 11111, 00001, 00011 implemented
// - Unsupported target: address/data access ignored
// - Bits 15:14 pick address, data, increment modes
// - Address mode reads/writes target pointer
// - Data mode accesses pointed register, pointer held
// - Mode 10 increments pointer after reads, writes
// - Mode 11 increments pointer after writes only
// - Station loads pointer before data accesses
// - Pointer kept between frames
`include "mdm_regs.svh"
module mdm_device
	import mdm_pkg::*;
(
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Address straps and captured address
	input  wire logic [3:0] bus_address_straps,
	output logic      [3:0] bus_address,
	// Management link
	mdm_link_if.device      link
);

	////////////////////////////////////////////////////////////////////////////
	// Helpers

	// Target code to storage slot
	function automatic logic [1:0] tgt_index(input logic [4:0] code);
		case (code)
			`MDM_DEV_GEN: tgt_index = `MDM_TGT_GEN;
			`MDM_DEV_PMA: tgt_index = `MDM_TGT_PMA;
			`MDM_DEV_VND: tgt_index = `MDM_TGT_VND;
			default:      tgt_index = `MDM_TGT_NONE;
		endcase
	endfunction: tgt_index

	// Slot and pointer to flat extended word index
	function automatic logic [5:0] ext_index(input logic [1:0] tgt, input logic [15:0] ptr);
		ext_index = {tgt, ptr[`MDM_EXT_IDX_W-1:0]};
	endfunction: ext_index

	////////////////////////////////////////////////////////////////////////////
	// Declarations

	logic [1:0]        sync1_reg;
	logic [1:0]        sync2_reg;
	logic [1:0]        sync3_reg;
	logic [1:0]        line_reg;
	logic              bit_tick;
	logic              mdio_bit;
	mdm_dev_state_type state_reg;
	logic [4:0]        cnt_reg;
	logic [11:0]       hdr_reg;
	logic [11:0]       hdr_next;
	logic [15:0]       dat_reg;
	logic [15:0]       wdata;
	logic              hit_reg;
	logic              rd_reg;
	logic              last_bit_reg;
	logic              out_reg;
	logic              oe_n_reg;
	logic              frame_hit;
	logic              wr_commit;
	logic              rd_done;
	logic [3:0]        addr_reg;
	logic [15:0]       dir_reg [0:`MDM_NUM_REGS-1];
	logic [15:0]       ext_reg [0:`MDM_EXT_WORDS-1];
	logic [15:0]       ptr_reg [0:2];
	logic [1:0]        fn;
	logic [1:0]        tgt;
	logic [15:0]       ptr_sel;
	logic [15:0]       rd_value;
	logic [4:0]        reg_addr;

	////////////////////////////////////////////////////////////////////////////
	// Link sampling

	// Three stages on {mdc, mdio}; a level counts once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= 2'h3;
			sync2_reg <= 2'h3;
			sync3_reg <= 2'h3;
			line_reg  <= 2'h3;
		end else begin
			sync1_reg <= {link.mdc, link.mdio};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			line_reg  <= (sync2_reg & ~(sync2_reg ^ sync3_reg)) | (line_reg & (sync2_reg ^ sync3_reg));
		end
	end

	// Stopped mdc simply gives no ticks, nothing times out
	assign bit_tick = (sync2_reg[1] == sync3_reg[1]) && sync3_reg[1] && !line_reg[1];
	assign mdio_bit = line_reg[0];

	////////////////////////////////////////////////////////////////////////////
	// Address straps

	// Reset here is synchronous, so the straps are clocked in while held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			addr_reg <= bus_address_straps;
		end
	end
	assign bus_address = addr_reg;

	////////////////////////////////////////////////////////////////////////////
	// Frame decode

	assign hdr_next  = {hdr_reg[10:0], mdio_bit};
	assign frame_hit = ((hdr_next[11:10] == `MDM_OP_READ) || (hdr_next[11:10] == `MDM_OP_WRITE))
		&& (hdr_next[9:5] == {1'b0, addr_reg});
	assign wdata     = {dat_reg[14:0], mdio_bit};
	assign wr_commit = bit_tick && (state_reg == DEV_DATA) && (cnt_reg == `MDM_DATA_LAST) && hit_reg && !rd_reg;
	assign rd_done   = bit_tick && (state_reg == DEV_DATA) && (cnt_reg == `MDM_DATA_LAST) && hit_reg && rd_reg;

	// Bit sequencer, one step per sampled mdc rise
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg    <= DEV_IDLE;
			cnt_reg      <= 5'h00;
			hdr_reg      <= 12'h000;
			dat_reg      <= 16'h0000;
			hit_reg      <= 1'b0;
			rd_reg       <= 1'b0;
			last_bit_reg <= 1'b1;
			out_reg      <= 1'b1;
			oe_n_reg     <= 1'b1;
		end else if (bit_tick) begin
			last_bit_reg <= mdio_bit;
			case (state_reg)
				DEV_IDLE: begin
					if (last_bit_reg && !mdio_bit) begin
						state_reg <= DEV_START;
					end
				end
				DEV_START: begin
					state_reg <= mdio_bit ? DEV_HDR : DEV_IDLE;
					cnt_reg   <= 5'h00;
				end
				DEV_HDR: begin
					hdr_reg <= hdr_next;
					if (cnt_reg == `MDM_HDR_LAST) begin
						state_reg <= DEV_TA;
						cnt_reg   <= `MDM_TA_FIRST;
						hit_reg   <= frame_hit;
						rd_reg    <= (hdr_next[11:10] == `MDM_OP_READ);
						dat_reg   <= rd_value;
					end else begin
						cnt_reg <= cnt_reg + 5'h01;
					end
				end
				DEV_TA: begin
					// First turnaround bit left undriven; zero driven for the second
					if (cnt_reg == `MDM_TA_FIRST) begin
						cnt_reg <= cnt_reg + 5'h01;
						if (hit_reg && rd_reg) begin
							oe_n_reg <= 1'b0;
							out_reg  <= 1'b0;
						end
					end else begin
						state_reg <= DEV_DATA;
						cnt_reg   <= 5'h00;
						if (hit_reg && rd_reg) begin
							out_reg <= dat_reg[15];
							dat_reg <= {dat_reg[14:0], 1'b0};
						end
					end
				end
				DEV_DATA: begin
					if (hit_reg && rd_reg) begin
						out_reg <= dat_reg[15];
						dat_reg <= {dat_reg[14:0], 1'b0};
					end else begin
						dat_reg <= wdata;
					end
					if (cnt_reg == `MDM_DATA_LAST) begin
						state_reg <= DEV_IDLE;
						oe_n_reg  <= 1'b1;
						out_reg   <= 1'b1;
					end else begin
						cnt_reg <= cnt_reg + 5'h01;
					end
				end
				default: begin
					state_reg <= DEV_IDLE;
					oe_n_reg  <= 1'b1;
				end
			endcase
		end
	end

	// Write frames keep the line released throughout
	assign link.dev_mdio_o    = out_reg;
	assign link.dev_mdio_oe_n = oe_n_reg;

	////////////////////////////////////////////////////////////////////////////
	// Extended access path

	// Current mode, target and its pointer
	always_comb begin
		fn      = dir_reg[`MDM_REG_ACCESS_CTRL][`MDM_FN_HI:`MDM_FN_LO];
		tgt     = tgt_index(dir_reg[`MDM_REG_ACCESS_CTRL][`MDM_DEV_HI:`MDM_DEV_LO]);
		ptr_sel = (tgt == `MDM_TGT_NONE) ? 16'h0000 : ptr_reg[tgt];
	end

	// Read value picked as the register address field completes
	always_comb begin
		reg_addr = hdr_next[4:0];
		if (reg_addr == `MDM_REG_ADDR_DATA) begin
			if (tgt == `MDM_TGT_NONE) begin
				rd_value = 16'h0000;
			end else if (fn == `MDM_FN_ADDR) begin
				rd_value = ptr_sel;
			end else begin
				rd_value = ext_reg[ext_index(tgt, ptr_sel)];
			end
		end else begin
			rd_value = dir_reg[reg_addr];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register file

	// Pointers persist across frames; only reset clears them
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < `MDM_NUM_REGS; i++) begin
				dir_reg[i] <= 16'h0000;
			end
			for (int i = 0; i < `MDM_EXT_WORDS; i++) begin
				ext_reg[i] <= 16'h0000;
			end
			for (int i = 0; i < 3; i++) begin
				ptr_reg[i] <= 16'h0000;
			end
		end else if (wr_commit) begin
			if (hdr_reg[4:0] == `MDM_REG_ADDR_DATA) begin
				if (tgt != `MDM_TGT_NONE) begin
					if (fn == `MDM_FN_ADDR) begin
						ptr_reg[tgt] <= wdata;
					end else begin
						ext_reg[ext_index(tgt, ptr_sel)] <= wdata;
						if (fn == `MDM_FN_INC_RW || fn == `MDM_FN_INC_WR) begin
							ptr_reg[tgt] <= ptr_sel + 16'h0001;
						end
					end
				end
			end else begin
				dir_reg[hdr_reg[4:0]] <= wdata;
			end
		end else if (rd_done && hdr_reg[4:0] == `MDM_REG_ADDR_DATA && tgt != `MDM_TGT_NONE
			&& fn == `MDM_FN_INC_RW) begin
			ptr_reg[tgt] <= ptr_sel + 16'h0001;
		end
	end

endmodule: mdm_device

/* File: rtl/mdm_regs.svh */
// Register map, field positions and timing counts of the management link
`ifndef MDM_REGS_SVH
`define MDM_REGS_SVH
// Direct register space of the device
`define MDM_NUM_REGS        32
`define MDM_REG_ACCESS_CTRL 5'h0d
`define MDM_REG_ADDR_DATA   5'h0e
// Access control fields
`define MDM_FN_HI           15
`define MDM_FN_LO           14
`define MDM_DEV_HI          4
`define MDM_DEV_LO          0
`define MDM_FN_ADDR         2'h0
`define MDM_FN_DATA         2'h1
`define MDM_FN_INC_RW       2'h2
`define MDM_FN_INC_WR       2'h3
// Target device codes and their storage slots
`define MDM_DEV_GEN         5'h1f
`define MDM_DEV_PMA         5'h01
`define MDM_DEV_VND         5'h03
`define MDM_TGT_GEN         2'h0
`define MDM_TGT_PMA         2'h1
`define MDM_TGT_VND         2'h2
`define MDM_TGT_NONE        2'h3
`define MDM_EXT_IDX_W       4
`define MDM_EXT_WORDS       48
// Frame layout
`define MDM_OP_READ         2'h2
`define MDM_OP_WRITE        2'h1
`define MDM_START           2'h1
`define MDM_TA_WRITE        2'h2
`define MDM_TA_READ         2'h3
`define MDM_HDR_LAST        5'h0b
`define MDM_TA_FIRST        5'h00
`define MDM_DATA_LAST       5'h0f
`define MDM_PRE_ONES        32'hffff_ffff
`define MDM_IDLE_DATA       16'hffff
`define MDM_LAST_BIT        6'h3f
`define MDM_DRIVE_END       6'h2d
`define MDM_SAMPLE_FIRST    6'h30
// Management clock timing
`define MDM_ACLK_PERIOD_NS  4
`define MDM_MDC_PERIOD_NS   160
`define MDM_MDC_HALF_CYC    (`MDM_MDC_PERIOD_NS / `MDM_ACLK_PERIOD_NS / 2)
// Station registers, byte offsets
`define MDM_AXI_FRAME_ADDR  8'h00
`define MDM_AXI_WDATA       8'h04
`define MDM_AXI_COMMAND     8'h08
`define MDM_AXI_STATUS      8'h0c
`define MDM_AXI_RDATA       8'h10
`define MDM_CMD_START       0
`define MDM_CMD_READ        1
`define MDM_RESP_OKAY       2'h0
`define MDM_RESP_SLVERR     2'h2
`endif

/* File: rtl/mdm_pkg.sv */
// Shared state types of both link ends
package mdm_pkg;
	typedef enum logic [4:0] {
		DEV_IDLE  = 5'h01,
		DEV_START = 5'h02,
		DEV_HDR   = 5'h04,
		DEV_TA    = 5'h08,
		DEV_DATA  = 5'h10
	} mdm_dev_state_type;
	typedef enum logic [1:0] {
		STA_IDLE = 2'h1,
		STA_RUN  = 2'h2
	} mdm_sta_state_type;
endpackage: mdm_pkg

/* File: rtl/mdm_link_if.sv */
// Management link wires between station and device, with line pullup
interface mdm_link_if;
	logic mdc;
	logic sta_mdio_o;
	logic sta_mdio_oe_n;
	logic dev_mdio_o;
	logic dev_mdio_oe_n;
	logic mdio;
	// Open line idles high; an enabled driver sets the level, and a low wins if both drive
	assign mdio = (sta_mdio_oe_n | sta_mdio_o) & (dev_mdio_oe_n | dev_mdio_o);
	modport station (output mdc, output sta_mdio_o, output sta_mdio_oe_n, input mdio);
	modport device (input mdc, input mdio, output dev_mdio_o, output dev_mdio_oe_n);
endinterface: mdm_link_if

/* File: rtl/mdm_station.sv */
// Station end: AXI4-Lite command registers driving management frames
`include "mdm_regs.svh"
module mdm_station
	import mdm_pkg::*;
(
	// Clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// AXI4-Lite slave
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Management link
	mdm_link_if.station      link
);

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
		merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
	endfunction: merge16

	logic [31:0]       awaddr_reg;
	logic [31:0]       wdata_reg;
	logic [3:0]        wstrb_reg;
	logic              aw_got_reg;
	logic              w_got_reg;
	logic              do_write;
	logic [9:0]        faddr_reg;
	logic [15:0]       faddr_merged;
	logic [15:0]       fwdata_reg;
	logic [15:0]       frdata_reg;
	logic              start;
	mdm_sta_state_type state_reg;
	logic              rd_reg;
	logic [5:0]        bit_reg;
	logic [63:0]       frame_reg;
	logic [4:0]        div_reg;
	logic              mdc_reg;
	logic              tick_rise;
	logic              tick_fall;
	logic              out_reg;
	logic              oe_n_reg;
	logic              sync1_reg;
	logic              sync2_reg;
	logic              sync3_reg;
	logic              mdio_reg;

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write path

	// Address and data taken in either order; response after both
	assign s_axi_awready = !aw_got_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_got_reg && !s_axi_bvalid;
	assign do_write      = aw_got_reg && w_got_reg && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_got_reg   <= 1'b0;
			w_got_reg    <= 1'b0;
			awaddr_reg   <= 32'h0000_0000;
			wdata_reg    <= 32'h0000_0000;
			wstrb_reg    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `MDM_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_got_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_got_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_got_reg   <= 1'b0;
				w_got_reg    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_reg[7:0] > `MDM_AXI_COMMAND) ? `MDM_RESP_SLVERR : `MDM_RESP_OKAY;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Frame address merged at full width, then cut to its ten bits
	assign faddr_merged = merge16({6'h00, faddr_reg}, wdata_reg, wstrb_reg);

	// Command registers; a start while busy is dropped
	assign start = do_write && awaddr_reg[7:0] == `MDM_AXI_COMMAND && wstrb_reg[0]
		&& wdata_reg[`MDM_CMD_START] && state_reg == STA_IDLE;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			faddr_reg  <= 10'h000;
			fwdata_reg <= 16'h0000;
		end else if (do_write && awaddr_reg[7:0] == `MDM_AXI_FRAME_ADDR) begin
			faddr_reg <= faddr_merged[9:0];
		end else if (do_write && awaddr_reg[7:0] == `MDM_AXI_WDATA) begin
			fwdata_reg <= merge16(fwdata_reg, wdata_reg, wstrb_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read path

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= `MDM_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= `MDM_RESP_OKAY;
			case (s_axi_araddr[7:0])
				`MDM_AXI_FRAME_ADDR: s_axi_rdata <= {22'h00_0000, faddr_reg};
				`MDM_AXI_WDATA:      s_axi_rdata <= {16'h0000, fwdata_reg};
				`MDM_AXI_COMMAND:    s_axi_rdata <= 32'h0000_0000;
				`MDM_AXI_STATUS:     s_axi_rdata <= {31'h0000_0000, state_reg == STA_RUN};
				`MDM_AXI_RDATA:      s_axi_rdata <= {16'h0000, frdata_reg};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `MDM_RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Management clock

	// Clock runs only during a frame; the device must cope with a stopped clock
	assign tick_rise = (state_reg == STA_RUN) && div_reg == 5'(`MDM_MDC_HALF_CYC - 1) && !mdc_reg;
	assign tick_fall = (state_reg == STA_RUN) && div_reg == 5'(`MDM_MDC_HALF_CYC - 1) && mdc_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn || state_reg != STA_RUN) begin
			div_reg <= 5'h00;
			mdc_reg <= 1'b0;
		end else if (tick_rise || tick_fall) begin
			div_reg <= 5'h00;
			mdc_reg <= !mdc_reg;
		end else begin
			div_reg <= div_reg + 5'h01;
		end
	end
	assign link.mdc = mdc_reg;

	////////////////////////////////////////////////////////////////////////////
	// Frame sequencer

	// Line input, three stages; a level counts once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= 1'b1;
			sync2_reg <= 1'b1;
			sync3_reg <= 1'b1;
			mdio_reg  <= 1'b1;
		end else begin
			sync1_reg <= link.mdio;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			mdio_reg  <= (sync2_reg == sync3_reg) ? sync3_reg : mdio_reg;
		end
	end

	// Ones lead every frame, so the bus idles a full mdc cycle and more first
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg  <= STA_IDLE;
			rd_reg     <= 1'b0;
			bit_reg    <= 6'h00;
			frame_reg  <= 64'h0000_0000_0000_0000;
			out_reg    <= 1'b1;
			oe_n_reg   <= 1'b1;
			frdata_reg <= 16'h0000;
		end else if (start) begin
			state_reg <= STA_RUN;
			rd_reg    <= wdata_reg[`MDM_CMD_READ];
			bit_reg   <= 6'h00;
			frame_reg <= {`MDM_PRE_ONES, `MDM_START, wdata_reg[`MDM_CMD_READ] ? `MDM_OP_READ : `MDM_OP_WRITE,
				faddr_reg, wdata_reg[`MDM_CMD_READ] ? `MDM_TA_READ : `MDM_TA_WRITE,
				wdata_reg[`MDM_CMD_READ] ? `MDM_IDLE_DATA : fwdata_reg};
			out_reg   <= 1'b1;
			oe_n_reg  <= 1'b0;
		end else if (tick_rise) begin
			if (rd_reg && bit_reg >= `MDM_SAMPLE_FIRST) begin
				frdata_reg <= {frdata_reg[14:0], mdio_reg};
			end
		end else if (tick_fall) begin
			if (bit_reg == `MDM_LAST_BIT) begin
				state_reg <= STA_IDLE;
				oe_n_reg  <= 1'b1;
				out_reg   <= 1'b1;
			end else begin
				bit_reg   <= bit_reg + 6'h01;
				frame_reg <= {frame_reg[62:0], 1'b1};
				out_reg   <= frame_reg[62];
				oe_n_reg  <= rd_reg && bit_reg >= `MDM_DRIVE_END;
			end
		end
	end
	assign link.sta_mdio_o    = out_reg;
	assign link.sta_mdio_oe_n = oe_n_reg;

endmodule: mdm_station

/* File: dv/mdm_link_properties.sv */
// Concurrent checks on the management link wires between station and device
module mdm_link_properties (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link wires
	input wire logic mdc,
	input wire logic sta_mdio_o,
	input wire logic sta_mdio_oe_n,
	input wire logic dev_mdio_o,
	input wire logic dev_mdio_oe_n,
	input wire logic mdio
);
	timeunit 1ns;
	timeprecision 100ps;
	////////////////////////////////////////////////////////////////////////////////
	logic [9:0] drive_cnt_reg;

	// Cycles the device holds the line; saturates so a stuck driver still fails
	always_ff @(posedge aclk) begin
		if (!aresetn || dev_mdio_oe_n) begin
			drive_cnt_reg <= 10'h000;
		end else if (drive_cnt_reg != 10'h3ff) begin
			drive_cnt_reg <= drive_cnt_reg + 10'h001;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_no_clash; !(!sta_mdio_oe_n && !dev_mdio_oe_n); endproperty
	a_no_clash: assert property (p_no_clash)
		else $error("both ends drive the data line");
	property p_ta_zero; $fell(dev_mdio_oe_n) |-> !dev_mdio_o; endproperty
	a_ta_zero: assert property (p_ta_zero)
		else $error("device turnaround bit is not zero");
	// Station must have let go well before the device takes the line
	property p_ta_release; $fell(dev_mdio_oe_n) |-> sta_mdio_oe_n && $past(sta_mdio_oe_n, 15); endproperty
	a_ta_release: assert property (p_ta_release)
		else $error("station still drove the first turnaround bit");
	property p_mdc_high; $rose(mdc) |-> ##19 mdc ##1 !mdc; endproperty
	a_mdc_high: assert property (p_mdc_high)
		else $error("management clock high phase is not 20 cycles");
	property p_mdc_low; $fell(mdc) |-> !mdc ##19 !mdc; endproperty
	a_mdc_low: assert property (p_mdc_low)
		else $error("management clock low phase too short");
	property p_sta_on_fall; $changed(sta_mdio_o) && !sta_mdio_oe_n |-> !mdc; endproperty
	a_sta_on_fall: assert property (p_sta_on_fall)
		else $error("station data moved while clock high");
	property p_dev_stable; $rose(mdc) && !dev_mdio_oe_n |-> $stable(dev_mdio_o)[*3]; endproperty
	a_dev_stable: assert property (p_dev_stable)
		else $error("device data moved at the sampling edge");
	// Zero plus 16 data bits; release comes right after the last one
	property p_drive_len; $rose(dev_mdio_oe_n) |-> drive_cnt_reg >= 10'h276 && drive_cnt_reg <= 10'h2b2; endproperty
	a_drive_len: assert property (p_drive_len)
		else $error("device drive span is not the read length");
	property p_preamble; $fell(sta_mdio_oe_n) |-> sta_mdio_o && !mdc; endproperty
	a_preamble: assert property (p_preamble)
		else $error("frame does not leave an idle high line");
	// Whenever the station lets go, the device is off and the line is back high
	property p_idle_high; $rose(sta_mdio_oe_n) |-> dev_mdio_oe_n && mdio; endproperty
	a_idle_high: assert property (p_idle_high)
		else $error("line not released high when the station lets go");

	c_read: cover property ($fell(dev_mdio_oe_n));
	c_frame: cover property ($fell(sta_mdio_oe_n));
	c_done: cover property ($rose(sta_mdio_oe_n));
endmodule: mdm_link_properties

/* File: dv/tb_mdio_mgmt_mmd_indirect_access.sv */
// Bench joining station and device, driven through the station registers
module tb_mdio_mgmt_mmd_indirect_access;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [4:0] DEV = 5'h05;
	logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp;
	logic [3:0]  straps, bus_address;
	logic [31:0] awaddr, wdata, araddr, rdata, q;
	logic [4:0]  codes [3] = '{5'h1f, 5'h01, 5'h03};
	int          n_fail, compares, cyc;

	////////////////////////////////////////////////////////////////////////////////
	mdm_link_if lk ();
	mdm_station u_mdm_station (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(lk));
	mdm_device u_mdm_device (.aclk(aclk), .aresetn(aresetn), .bus_address_straps(straps),
		.bus_address(bus_address), .link(lk));
	mdm_link_properties u_mdm_link_properties (.aclk(aclk), .aresetn(aresetn), .mdc(lk.mdc),
		.sta_mdio_o(lk.sta_mdio_o), .sta_mdio_oe_n(lk.sta_mdio_oe_n), .dev_mdio_o(lk.dev_mdio_o),
		.dev_mdio_oe_n(lk.dev_mdio_oe_n), .mdio(lk.mdio));

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask: chk

	// Address and data offered together, each dropped once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= {24'h00_0000, a};
		wdata <= d;
		awvalid <= 1'h1;
		wvalid <= 1'h1;
		bready <= 1'h1;
		do begin
			@(posedge aclk);
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
		end while (bvalid !== 1'h1);
		chk({30'h0000_0000, bresp}, 32'h0000_0000);
		bready <= 1'h0;
	endtask: axw

	task automatic axr(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= {24'h00_0000, a};
		arvalid <= 1'h1;
		rready <= 1'h1;
		do begin
			@(posedge aclk);
			if (arready) arvalid <= 1'h0;
		end while (rvalid !== 1'h1);
		d = rdata;
		chk({30'h0000_0000, rresp}, 32'h0000_0000);
		rready <= 1'h0;
	endtask: axr

	// One whole link frame; busy polled until the final clock fall
	task automatic frame(input logic [4:0] dv, input logic [4:0] rg, input logic [15:0] d, input logic rd,
		output logic [31:0] r);
		logic [31:0] st;
		axw(8'h00, {22'h00_0000, dv, rg});
		axw(8'h04, {16'h0000, d});
		axw(8'h08, {30'h0000_0000, rd, 1'h1});
		do axr(8'h0c, st); while (st[0] !== 1'h0);
		axr(8'h10, r);
	endtask: frame

	task automatic wr(input logic [4:0] rg, input logic [15:0] d);
		logic [31:0] r;
		frame(DEV, rg, d, 1'h0, r);
	endtask: wr

	task automatic rdc(input logic [4:0] dv, input logic [4:0] rg, input logic [15:0] e);
		logic [31:0] r;
		frame(dv, rg, 16'h0000, 1'h1, r);
		chk({16'h0000, r[15:0]}, {16'h0000, e});
	endtask: rdc

	task automatic report_and_stop;
		if (n_fail == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask: report_and_stop

	////////////////////////////////////////////////////////////////////////////////
	// Clock at 250 MHz
	initial begin
		aclk = 1'h0;
		forever #2 aclk = ~aclk;
	end

	// Ceiling covers about 38 frames of 64 link bits at 40 cycles each; the run uses 36
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 98000) begin
			n_fail++;
			report_and_stop;
		end
	end

	// Main sequence
	initial begin
		aresetn = 1'h0;
		straps = 4'h5;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, wdata, araddr} = 96'h0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'h1;
		repeat (8) @(posedge aclk);
		chk({28'h000_0000, bus_address}, 32'h0000_0005);
		wr(5'h1f, 16'ha5c3);
		rdc(DEV, 5'h1f, 16'ha5c3);
		frame(5'h15, 5'h1f, 16'h0f0f, 1'h0, q);
		rdc(5'h15, 5'h1f, 16'hffff);
		rdc(DEV, 5'h1f, 16'ha5c3);
		// Each target space gets its own word at pointer 9
		for (int i = 0; i < 3; i++) begin
			wr(5'h0d, {11'h000, codes[i]});
			wr(5'h0e, 16'h0009);
			wr(5'h0d, {2'h1, 9'h000, codes[i]});
			wr(5'h0e, {11'h2d0, codes[i]});
			rdc(DEV, 5'h0e, {11'h2d0, codes[i]});
		end
		wr(5'h0d, 16'h401f);
		rdc(DEV, 5'h0e, 16'h5a1f);
		rdc(DEV, 5'h0e, 16'h5a1f);
		wr(5'h0d, 16'h801f);
		wr(5'h0e, 16'haaaa);
		rdc(DEV, 5'h0e, 16'h0000);
		wr(5'h0d, 16'hc01f);
		rdc(DEV, 5'h0e, 16'h0000);
		wr(5'h0e, 16'hbbbb);
		// Unsupported target must not move the pointer
		wr(5'h0d, 16'h0002);
		wr(5'h0e, 16'h0007);
		wr(5'h0d, 16'h001f);
		rdc(DEV, 5'h0e, 16'h000c);
		wr(5'h0e, 16'h000b);
		wr(5'h0d, 16'h401f);
		rdc(DEV, 5'h0e, 16'hbbbb);
		report_and_stop;
	end
endmodule: tb_mdio_mgmt_mmd_indirect_access
